// ### bench/tdx_monitor.sv
// Purpose: Port checks for the trap delegation block
// Assumes: Bound to tdx_trap_delegation, one clock
// Notes: Status reads assume machine requester
`timescale 1ns/1ps
module tdx_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic csr_ack,
  input wire logic csr_illegal,
  input wire logic [31:0] csr_rdata,
  // Traps
  input wire logic trap_valid,
  input wire tdx_pkg::tdx_priv_t trap_priv,
  input wire logic trap_done,
  input wire logic [31:0] handler_pc,
  input wire tdx_pkg::tdx_priv_t handler_priv,
  input wire logic ret_valid,
  input wire logic ret_done,
  // Extensions
  input wire tdx_pkg::tdx_ext_op_t float_op,
  input wire tdx_pkg::tdx_ext_op_t other_op,
  input wire logic ext_fault,
  input wire logic [3:0] level_int_enable
);
  import tdx_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_read(a);
    csr_valid && !csr_write && csr_addr == a;
  endsequence
  sequence s_off_use;
    float_op == EXT_DISABLE ##1 (float_op == EXT_NONE && !csr_valid) ##1
      (float_op inside {EXT_READ, EXT_MODIFY, EXT_UNCONFIG});
  endsequence
  sequence s_on_use;
    float_op == EXT_ENABLE ##1 (float_op == EXT_NONE && !csr_valid) ##1
      (float_op == EXT_READ && other_op == EXT_NONE);
  endsequence
  sequence s_deleg;
    trap_valid ##1 trap_done && handler_priv != PRIV_M;
  endsequence
  a_ack_next: assert property (csr_valid |=> csr_ack)
    else $error("ack missing");
  a_hyp_absent: assert property (csr_valid && csr_addr[9:8] == 2'h2 |=> csr_illegal)
    else $error("absent level accepted");
  a_tvec_align: assert property (s_read(12'h305) |=> csr_rdata[1:0] == 2'h0)
    else $error("vector base unaligned");
  a_edeleg_mask: assert property (s_read(12'h302) |=> (csr_rdata & ~EDELEG_MASK) == 32'h0)
    else $error("unsupported exception bit set");
  a_ideleg_mask: assert property (s_read(12'h303) |=> (csr_rdata & ~IDELEG_MASK) == 32'h0)
    else $error("unsupported interrupt bit set");
  a_dirty_sum: assert property (s_read(12'h300) |=>
    csr_rdata[31] == (csr_rdata[14:13] == 2'h3 || csr_rdata[16:15] == 2'h3))
    else $error("summary bit wrong");
  a_off_faults: assert property (s_off_use |-> ext_fault)
    else $error("off unit used without fault");
  a_enable_init: assert property (s_on_use |-> !ext_fault)
    else $error("enabled unit faulted");
  a_mtrap_stays: assert property (trap_valid && trap_priv == PRIV_M |=>
    trap_done && handler_priv == PRIV_M)
    else $error("machine trap left machine");
  a_deleg_clear: assert property (s_deleg |-> level_int_enable[handler_priv] == 1'b0)
    else $error("target enable not cleared");
  a_handler_align: assert property (trap_done |-> handler_pc[1:0] == 2'h0)
    else $error("handler address unaligned");
  a_ret_done: assert property (ret_valid && !trap_valid |=> ret_done)
    else $error("return not done");
endmodule
bind tdx_trap_delegation tdx_monitor tdx_monitor_inst (.clk, .reset, .csr_valid, .csr_write,
  .csr_addr, .csr_ack, .csr_illegal, .csr_rdata, .trap_valid, .trap_priv, .trap_done,
  .handler_pc, .handler_priv, .ret_valid, .ret_done, .float_op, .other_op, .ext_fault,
  .level_int_enable);

// ### bench/tdx_pipe_model.sv
// Purpose: Pipeline model issuing traps, returns and extension ops
// Assumes: Called from the bench on clk
// Notes: Released trap address shows inverted value
`timescale 1ns/1ps
module tdx_pipe_model (
  // Clock
  input wire logic clk,
  // Trap and return
  output logic trap_valid,
  output logic trap_is_int,
  output logic [4:0] trap_code,
  output logic [31:0] trap_pc,
  output tdx_pkg::tdx_priv_t trap_priv,
  input wire logic trap_done,
  output logic ret_valid,
  output tdx_pkg::tdx_priv_t ret_level,
  // Extension ops
  output tdx_pkg::tdx_ext_op_t float_op,
  output tdx_pkg::tdx_ext_op_t other_op,
  input wire logic ext_fault
);
  import tdx_pkg::*;
  initial begin
    trap_valid = 1'b0;
    trap_is_int = 1'b0;
    trap_code = 5'h0;
    trap_pc = 32'h0;
    trap_priv = PRIV_M;
    ret_valid = 1'b0;
    ret_level = PRIV_M;
    float_op = EXT_NONE;
    other_op = EXT_NONE;
  end
  task automatic trap(input logic i, input logic [4:0] c, input logic [31:0] pc,
    input tdx_priv_t p, output logic ok);
    @(posedge clk);
    trap_valid <= 1'b1;
    trap_is_int <= i;
    trap_code <= c;
    trap_pc <= pc;
    trap_priv <= p;
    @(posedge clk);
    trap_valid <= 1'b0;
    trap_pc <= ~pc;
    #1 ok = trap_done;
  endtask
  task automatic ret(input tdx_priv_t l);
    @(posedge clk);
    ret_valid <= 1'b1;
    ret_level <= l;
    @(posedge clk);
    ret_valid <= 1'b0;
    #1;
  endtask
  // Fault seen in the same cycle as the op
  task automatic ext(input tdx_ext_op_t f, input tdx_ext_op_t o, output logic flt);
    @(posedge clk);
    float_op <= f;
    other_op <= o;
    #1 flt = ext_fault;
    @(posedge clk);
    float_op <= EXT_NONE;
    other_op <= EXT_NONE;
  endtask
endmodule

// ### bench/tdx_trap_delegation_bench.sv
// Purpose: Self-checking bench for trap delegation and extension status
// Assumes: Pipeline model drives trap and extension ports
// Notes: Random values from a fixed-seed xorshift
`timescale 1ns/1ps
module tdx_trap_delegation_bench;
  import tdx_pkg::*;
  logic clk, reset, csr_valid, csr_write, csr_ack, csr_illegal, ill, ok, flt;
  logic trap_valid, trap_is_int, trap_done, ret_valid, ret_done, ext_fault;
  logic [11:0] csr_addr;
  logic [4:0] trap_code;
  logic [3:0] level_int_enable;
  logic [31:0] csr_wdata, csr_rdata, trap_pc, handler_pc, ret_pc, rd, rnd, tv, pc;
  tdx_priv_t csr_priv, trap_priv, handler_priv, ret_level, ret_priv;
  tdx_ext_op_t float_op, other_op, of, oo;
  tdx_ext_op_t cor [9];
  tdx_xs_t fs, xs;
  int mismatches, num_checks;
  tdx_trap_delegation tdx_trap_delegation_inst (.clk, .reset, .csr_valid, .csr_write,
    .csr_addr, .csr_wdata, .csr_priv, .csr_ack, .csr_illegal, .csr_rdata, .trap_valid,
    .trap_is_int, .trap_code, .trap_pc, .trap_priv, .trap_done, .handler_pc, .handler_priv,
    .ret_valid, .ret_level, .ret_done, .ret_pc, .ret_priv, .float_op, .other_op, .ext_fault,
    .level_int_enable);
  tdx_pipe_model tdx_pipe_model_inst (.clk, .trap_valid, .trap_is_int, .trap_code, .trap_pc,
    .trap_priv, .trap_done, .ret_valid, .ret_level, .float_op, .other_op, .ext_fault);
  function automatic logic [31:0] xs32(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic tdx_xs_t nxt(input tdx_xs_t s, input tdx_ext_op_t o);
    if (o == EXT_ENABLE) return XS_INIT;
    if (o == EXT_DISABLE || s == XS_OFF) return o == EXT_DISABLE ? XS_OFF : s;
    if (o == EXT_MODIFY) return XS_DIRTY;
    return o == EXT_UNCONFIG ? XS_INIT : s;
  endfunction
  function automatic logic bad(input tdx_xs_t s, input tdx_ext_op_t o);
    return s == XS_OFF && o inside {EXT_READ, EXT_MODIFY, EXT_UNCONFIG};
  endfunction
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    csr_valid <= 1'b1;
    csr_write <= w;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clk);
    csr_valid <= 1'b0;
    csr_wdata <= ~d;
    n = 0;
    #1;
    while (csr_ack !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 4) begin
      mismatches++;
      finish_test();
    end
    rd = csr_rdata;
    ill = csr_illegal;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    csr(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    csr_valid = 1'b0;
    csr_write = 1'b0;
    csr_addr = 12'h0;
    csr_wdata = 32'h0;
    csr_priv = PRIV_M;
    mismatches = 0;
    num_checks = 0;
    rnd = 32'h0000E850;
    fs = XS_OFF;
    xs = XS_OFF;
    cor = '{EXT_READ, EXT_MODIFY, EXT_ENABLE, EXT_READ, EXT_MODIFY, EXT_UNCONFIG,
      EXT_DISABLE, EXT_UNCONFIG, EXT_ENABLE};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdchk(12'h302, DELEG_RESET);
    rdchk(12'h303, DELEG_RESET);
    rdchk(12'h305, TVEC_RESET);
    rdchk(12'h300, 32'h0);
    csr(1'b0, 12'h205, 32'h0);
    check(ill, 1'b1);
    @(posedge clk);
    csr_priv <= PRIV_S;
    csr(1'b0, 12'h305, 32'h0);
    check(ill, 1'b1);
    rdchk(12'h105, TVEC_RESET);
    @(posedge clk);
    csr_priv <= PRIV_M;
    csr(1'b1, 12'h302, 32'hFFFFFFFF);
    rdchk(12'h302, EDELEG_MASK);
    csr(1'b1, 12'h303, 32'hFFFFFFFF);
    rdchk(12'h303, IDELEG_MASK);
    check(rd[INT_STIMER_BIT], 1'b1);
    rnd = xs32(rnd);
    tv = rnd;
    csr(1'b1, 12'h305, tv);
    rdchk(12'h305, tv & TVEC_ALIGN);
    pc = xs32(rnd);
    tdx_pipe_model_inst.trap(1'b0, 5'h2, pc, PRIV_M, ok);
    check(ok, 1'b1);
    check(handler_pc, tv & TVEC_ALIGN);
    check(handler_priv, PRIV_M);
    csr(1'b1, 12'h302, 32'h100);
    csr(1'b1, 12'h300, 32'h2);
    rnd = xs32(pc);
    csr(1'b1, 12'h105, rnd);
    tdx_pipe_model_inst.trap(1'b0, 5'h8, rnd, PRIV_S, ok);
    check(handler_priv, PRIV_S);
    check(handler_pc, rnd & TVEC_ALIGN);
    rdchk(12'h142, 32'h8);
    rdchk(12'h141, rnd);
    rdchk(12'h342, 32'h2);
    rdchk(12'h341, pc);
    rdchk(12'h300, 32'h120);
    csr(1'b1, 12'h102, 32'h100);
    tdx_pipe_model_inst.trap(1'b0, 5'h8, pc, PRIV_U, ok);
    check(handler_priv, PRIV_U);
    check(handler_pc, TVEC_RESET);
    rdchk(12'h042, 32'h8);
    tdx_pipe_model_inst.trap(1'b1, 5'h5, pc, PRIV_U, ok);
    check(handler_priv, PRIV_S);
    rdchk(12'h142, 32'h80000005);
    tdx_pipe_model_inst.ret(PRIV_S);
    check(ret_pc, pc);
    check(ret_priv, PRIV_U);
    tdx_pipe_model_inst.ext(EXT_ENABLE, EXT_NONE, flt);
    tdx_pipe_model_inst.ext(EXT_READ, EXT_NONE, flt);
    check(flt, 1'b0);
    tdx_pipe_model_inst.ext(EXT_DISABLE, EXT_NONE, flt);
    tdx_pipe_model_inst.ext(EXT_READ, EXT_NONE, flt);
    check(flt, 1'b1);
    for (int i = 0; i < 40; i++) begin
      rnd = xs32(rnd);
      of = i < 9 ? cor[i] : tdx_ext_op_t'(rnd[2:0] % 3'h6);
      oo = i < 9 ? EXT_NONE : tdx_ext_op_t'(rnd[5:3] % 3'h6);
      if (i > 9 && rnd[8]) begin
        csr(1'b1, 12'h300, {17'h0, rnd[10:9], 13'h0});
        fs = tdx_xs_t'(rnd[10:9]);
      end
      tdx_pipe_model_inst.ext(of, oo, flt);
      check(flt, bad(fs, of) || bad(xs, oo));
      fs = nxt(fs, of);
      xs = nxt(xs, oo);
      csr(1'b0, 12'h300, 32'h0);
      check(rd[16:13], {xs, fs});
      check(rd[31], fs == XS_DIRTY || xs == XS_DIRTY);
    end
    finish_test();
  end
endmodule

// ### rtl/tdx_ext_if.sv
// Purpose: Carrier between the trap block and the extension status tracker
// Assumes: One op per unit per cycle
// Notes: Only the float unit status is software writable
`timescale 1ns/1ps
interface tdx_ext_if;
  import tdx_pkg::*;
  tdx_ext_op_t op [EXT_UNITS];
  logic wr_en;
  tdx_xs_t wr_val;
  tdx_xs_t status [EXT_UNITS];
  logic [EXT_UNITS-1:0] fault;
  modport ctrl (output op, output wr_en, output wr_val, input status, input fault);
  modport unit (input op, input wr_en, input wr_val, output status, output fault);
endinterface

// ### rtl/tdx_ext_status.sv
// Purpose: Four-state context status of the float unit and other extensions
// Assumes: Ops come from the pipeline on the same clock
// Notes: One copy for all privilege modes
`timescale 1ns/1ps
module tdx_ext_status (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Status link
  tdx_ext_if.unit ext
);
  import tdx_pkg::*;

  tdx_xs_t st [EXT_UNITS];

  generate
    for (genvar u = 0; u < EXT_UNITS; u++) begin : g_unit
      // Single unbanked copy per unit
      always_ff @(posedge clk) begin
        if (reset) begin
          st[u] <= EXT_RESET;
        end else begin
          unique case (ext.op[u])
            EXT_DISABLE: st[u] <= XS_OFF;
            EXT_ENABLE: st[u] <= XS_INIT;
            EXT_MODIFY: begin
              if (st[u] != XS_OFF) begin
                st[u] <= XS_DIRTY;
              end
            end
            EXT_UNCONFIG: begin
              if (st[u] != XS_OFF) begin
                st[u] <= XS_INIT;
              end
            end
            EXT_READ: st[u] <= st[u];
            EXT_NONE: begin
              if (u == EXT_FLOAT && ext.wr_en) begin
                st[u] <= ext.wr_val;
              end
            end
            default: st[u] <= st[u];
          endcase
        end
      end

      // Off unit refuses use and stays Off
      assign ext.fault[u] = (st[u] == XS_OFF) &&
        (ext.op[u] == EXT_READ || ext.op[u] == EXT_MODIFY ||
         ext.op[u] == EXT_UNCONFIG);
      assign ext.status[u] = st[u];
    end
  endgenerate
endmodule

// ### rtl/tdx_pkg.sv
// Purpose: Shared types and constants for the trap delegation block
// Assumes: 32-bit registers, machine/supervisor/user modes with user traps
// Notes: Mode set is fixed by the HAS_ constants below
package tdx_pkg;
  typedef enum logic [1:0] {
    PRIV_U = 2'h0,
    PRIV_S = 2'h1,
    PRIV_H = 2'h2,
    PRIV_M = 2'h3
  } tdx_priv_t;

  typedef enum logic [1:0] {
    XS_OFF = 2'h0,
    XS_INIT = 2'h1,
    XS_CLEAN = 2'h2,
    XS_DIRTY = 2'h3
  } tdx_xs_t;

  typedef enum logic [2:0] {
    EXT_NONE = 3'h0,
    EXT_READ = 3'h1,
    EXT_MODIFY = 3'h2,
    EXT_UNCONFIG = 3'h3,
    EXT_DISABLE = 3'h4,
    EXT_ENABLE = 3'h5
  } tdx_ext_op_t;

  localparam int XLEN = 32;
  localparam int EXT_UNITS = 2;
  localparam int EXT_FLOAT = 0;
  localparam int EXT_OTHER = 1;

  // Supported privilege modes
  localparam logic HAS_H = 1'b0;
  localparam logic HAS_S = 1'b1;
  localparam logic HAS_UTRAP = 1'b1;
  localparam logic [3:0] LVL_PRESENT = {1'b1, HAS_H, HAS_S, HAS_UTRAP};
  localparam logic DELEG_ON = HAS_H | HAS_S | HAS_UTRAP;

  // Delegatable causes
  localparam logic [31:0] EDELEG_MASK = 32'h0000B3FF;
  localparam logic [31:0] IDELEG_MASK = 32'h00000777;
  localparam int INT_STIMER_BIT = 5;

  // Register addresses: level in bits 9:8, function in bits 7:0
  localparam int CSR_LVL_LSB = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_EDELEG = 8'h02;
  localparam logic [7:0] OFS_IDELEG = 8'h03;
  localparam logic [7:0] OFS_TVEC = 8'h05;
  localparam logic [7:0] OFS_EPC = 8'h41;
  localparam logic [7:0] OFS_CAUSE = 8'h42;

  // Status word layout
  localparam int ST_IE_LSB = 0;
  localparam int ST_PIE_LSB = 4;
  localparam int ST_SPP = 8;
  localparam int ST_HPP_LSB = 9;
  localparam int ST_MPP_LSB = 11;
  localparam int ST_FS_LSB = 13;
  localparam int ST_XS_LSB = 15;
  localparam int ST_SD = 31;
  localparam int CAUSE_INT_BIT = 31;

  // Values after reset
  localparam logic [31:0] TVEC_RESET = 32'h00000100;
  localparam logic [31:0] DELEG_RESET = 32'h00000000;
  localparam logic [31:0] TVEC_ALIGN = 32'hFFFFFFFC;
  localparam tdx_priv_t PP_RESET = PRIV_U;
  localparam tdx_xs_t EXT_RESET = XS_OFF;
endpackage

// ### rtl/tdx_trap_delegation.sv
// Purpose: Trap vector base, trap delegation and extension status of a hart
// Assumes: Pipeline reports traps, returns and extension ops on clk
// Notes: Register accesses answer one cycle later on csr_ack
`timescale 1ns/1ps
module tdx_trap_delegation (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [tdx_pkg::XLEN-1:0] csr_wdata,
  input wire tdx_pkg::tdx_priv_t csr_priv,
  output logic csr_ack,
  output logic csr_illegal,
  output logic [tdx_pkg::XLEN-1:0] csr_rdata,
  // Trap report
  input wire logic trap_valid,
  input wire logic trap_is_int,
  input wire logic [4:0] trap_code,
  input wire logic [tdx_pkg::XLEN-1:0] trap_pc,
  input wire tdx_pkg::tdx_priv_t trap_priv,
  output logic trap_done,
  output logic [tdx_pkg::XLEN-1:0] handler_pc,
  output tdx_pkg::tdx_priv_t handler_priv,
  // Trap return
  input wire logic ret_valid,
  input wire tdx_pkg::tdx_priv_t ret_level,
  output logic ret_done,
  output logic [tdx_pkg::XLEN-1:0] ret_pc,
  output tdx_pkg::tdx_priv_t ret_priv,
  // Extension state
  input wire tdx_pkg::tdx_ext_op_t float_op,
  input wire tdx_pkg::tdx_ext_op_t other_op,
  output logic ext_fault,
  output logic [3:0] level_int_enable
);
  import tdx_pkg::*;

  function automatic logic csr_exists(input logic [11:0] a);
    logic [1:0] l;
    logic [7:0] o;
    l = a[CSR_LVL_LSB+:2];
    o = a[7:0];
    csr_exists = (a[11:10] == 2'b00) && LVL_PRESENT[l] &&
      (o == OFS_TVEC || o == OFS_EPC || o == OFS_CAUSE ||
       (o == OFS_STATUS && l == PRIV_M) ||
       ((o == OFS_EDELEG || o == OFS_IDELEG) && l != PRIV_U));
  endfunction

  // Bits a level may delegate downward
  function automatic logic [XLEN-1:0] deleg_mask(input tdx_priv_t l,
                                                  input logic is_int);
    logic lower;
    unique case (l)
      PRIV_M: lower = DELEG_ON;
      PRIV_H: lower = HAS_S;
      PRIV_S: lower = HAS_UTRAP;
      PRIV_U: lower = 1'b0;
    endcase
    deleg_mask = is_int ? IDELEG_MASK : EDELEG_MASK;
    if (!lower || !LVL_PRESENT[l]) begin
      deleg_mask = '0;
    end
  endfunction

  // Handler level for a trap from mode p
  function automatic tdx_priv_t route(input tdx_priv_t p, input logic mb,
                                      input logic hb, input logic sb);
    route = PRIV_M;
    if (mb && p != PRIV_M) begin
      if (HAS_H) begin
        route = PRIV_H;
      end else if (HAS_S) begin
        route = PRIV_S;
      end else begin
        route = PRIV_U;
      end
      if (route == PRIV_H && hb && p <= PRIV_S && HAS_S) begin
        route = PRIV_S;
      end
      if (route == PRIV_S && sb && p == PRIV_U && HAS_UTRAP) begin
        route = PRIV_U;
      end
    end
  endfunction

  tdx_ext_if ext ();

  tdx_ext_status u_ext (
    .clk(clk),
    .reset(reset),
    .ext(ext.unit)
  );

  logic [XLEN-1:0] tvec [4];
  logic [XLEN-1:0] epc [4];
  logic [XLEN-1:0] cause [4];
  logic [XLEN-1:0] edeleg [4];
  logic [XLEN-1:0] ideleg [4];
  logic [3:0] ie;
  logic [3:0] pie;
  tdx_priv_t pp [4];

  tdx_priv_t acc_lvl;
  logic [7:0] acc_ofs;
  logic acc_ok;
  logic wr_en;
  logic [XLEN-1:0] rd_val;
  logic [XLEN-1:0] st_word;
  tdx_xs_t xs_sum;
  logic mb;
  logic hb;
  logic sb;
  tdx_priv_t tgt;

  assign acc_lvl = tdx_priv_t'(csr_addr[CSR_LVL_LSB+:2]);
  assign acc_ofs = csr_addr[7:0];
  assign acc_ok = csr_exists(csr_addr) && (csr_priv >= acc_lvl);
  assign wr_en = csr_valid && csr_write && acc_ok;

  // Delegation lookup by cause code
  always_comb begin
    if (trap_is_int) begin
      mb = ideleg[PRIV_M][trap_code];
      hb = ideleg[PRIV_H][trap_code];
      sb = ideleg[PRIV_S][trap_code];
    end else begin
      mb = edeleg[PRIV_M][trap_code];
      hb = edeleg[PRIV_H][trap_code];
      sb = edeleg[PRIV_S][trap_code];
    end
    tgt = route(trap_priv, mb, hb, sb);
  end

  // Extension status link
  assign ext.op[EXT_FLOAT] = float_op;
  assign ext.op[EXT_OTHER] = other_op;
  assign ext.wr_en = wr_en && acc_ofs == OFS_STATUS;
  assign ext.wr_val = tdx_xs_t'(csr_wdata[ST_FS_LSB+:2]);
  assign ext_fault = |ext.fault;

  // Summary of non-float extensions
  always_comb begin
    xs_sum = XS_OFF;
    for (int u = EXT_FLOAT + 1; u < EXT_UNITS; u++) begin
      if (ext.status[u] > xs_sum) begin
        xs_sum = ext.status[u];
      end
    end
  end

  // Status word assembly
  always_comb begin
    st_word = '0;
    st_word[ST_IE_LSB+:4] = ie & LVL_PRESENT;
    st_word[ST_PIE_LSB+:4] = pie & LVL_PRESENT;
    st_word[ST_SPP] = HAS_S & pp[PRIV_S][0];
    st_word[ST_HPP_LSB+:2] = HAS_H ? pp[PRIV_H] : 2'h0;
    st_word[ST_MPP_LSB+:2] = pp[PRIV_M];
    st_word[ST_FS_LSB+:2] = ext.status[EXT_FLOAT];
    st_word[ST_XS_LSB+:2] = xs_sum;
    st_word[ST_SD] = (ext.status[EXT_FLOAT] == XS_DIRTY) ||
      (xs_sum == XS_DIRTY);
  end

  // Read multiplexer
  always_comb begin
    rd_val = '0;
    unique case (acc_ofs)
      OFS_STATUS: rd_val = st_word;
      OFS_EDELEG: rd_val = edeleg[acc_lvl];
      OFS_IDELEG: rd_val = ideleg[acc_lvl];
      OFS_TVEC: rd_val = tvec[acc_lvl];
      OFS_EPC: rd_val = epc[acc_lvl];
      OFS_CAUSE: rd_val = cause[acc_lvl];
      default: rd_val = '0;
    endcase
  end

  // Trap vector bases
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int l = 0; l < 4; l++) begin
        tvec[l] <= TVEC_RESET & TVEC_ALIGN;
      end
    end else if (wr_en && acc_ofs == OFS_TVEC) begin
      tvec[acc_lvl] <= csr_wdata & TVEC_ALIGN;
    end
  end

  // Delegation registers
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int l = 0; l < 4; l++) begin
        edeleg[l] <= DELEG_RESET;
        ideleg[l] <= DELEG_RESET;
      end
    end else if (wr_en && acc_ofs == OFS_EDELEG) begin
      edeleg[acc_lvl] <= csr_wdata & deleg_mask(acc_lvl, 1'b0);
    end else if (wr_en && acc_ofs == OFS_IDELEG) begin
      ideleg[acc_lvl] <= csr_wdata & deleg_mask(acc_lvl, 1'b1);
    end
  end

  // Cause and return address per level
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int l = 0; l < 4; l++) begin
        epc[l] <= '0;
        cause[l] <= '0;
      end
    end else if (trap_valid) begin
      cause[tgt] <= '0;
      cause[tgt][CAUSE_INT_BIT] <= trap_is_int;
      cause[tgt][4:0] <= trap_code;
      epc[tgt] <= trap_pc;
    end else if (wr_en && acc_ofs == OFS_EPC) begin
      epc[acc_lvl] <= csr_wdata;
    end else if (wr_en && acc_ofs == OFS_CAUSE) begin
      cause[acc_lvl] <= csr_wdata;
    end
  end

  // Enable, previous enable and previous mode fields
  always_ff @(posedge clk) begin
    if (reset) begin
      ie <= '0;
      pie <= '0;
      for (int l = 0; l < 4; l++) begin
        pp[l] <= PP_RESET;
      end
    end else if (trap_valid) begin
      pie[tgt] <= ie[trap_priv];
      ie[tgt] <= 1'b0;
      pp[tgt] <= trap_priv;
    end else if (ret_valid) begin
      ie[ret_level] <= pie[ret_level];
      pie[ret_level] <= 1'b1;
      pp[ret_level] <= PP_RESET;
    end else if (wr_en && acc_ofs == OFS_STATUS) begin
      ie <= csr_wdata[ST_IE_LSB+:4] & LVL_PRESENT;
      pie <= csr_wdata[ST_PIE_LSB+:4] & LVL_PRESENT;
      pp[PRIV_S] <= tdx_priv_t'({1'b0, csr_wdata[ST_SPP]});
      pp[PRIV_H] <= tdx_priv_t'(csr_wdata[ST_HPP_LSB+:2]);
      pp[PRIV_M] <= tdx_priv_t'(csr_wdata[ST_MPP_LSB+:2]);
    end
  end

  // Trap and return answers
  always_ff @(posedge clk) begin
    if (reset) begin
      trap_done <= 1'b0;
      handler_pc <= '0;
      handler_priv <= PRIV_M;
      ret_done <= 1'b0;
      ret_pc <= '0;
      ret_priv <= PRIV_M;
    end else begin
      trap_done <= trap_valid;
      ret_done <= ret_valid && !trap_valid;
      if (trap_valid) begin
        handler_pc <= tvec[tgt];
        handler_priv <= tgt;
      end
      if (ret_valid && !trap_valid) begin
        ret_pc <= epc[ret_level];
        ret_priv <= pp[ret_level];
      end
    end
  end

  // Register access answer
  always_ff @(posedge clk) begin
    if (reset) begin
      csr_ack <= 1'b0;
      csr_illegal <= 1'b0;
      csr_rdata <= '0;
    end else begin
      csr_ack <= csr_valid;
      csr_illegal <= csr_valid && !acc_ok;
      csr_rdata <= (csr_valid && acc_ok) ? rd_val : '0;
    end
  end

  assign level_int_enable = ie;
endmodule
